/* File: hdl/uart_flow_pkg.sv */
// constants shared by the baud/flow-control block, its checker and its bench
// assumes one 100 MHz clock; register port addresses are byte indices
package uart_flow_pkg;

	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_DIV_LOW   = 5'h00;
	localparam logic [4:0] ADDR_DIV_HIGH  = 5'h01;
	localparam logic [4:0] ADDR_FRACTION  = 5'h02;
	localparam logic [4:0] ADDR_ENHANCED  = 5'h03;
	localparam logic [4:0] ADDR_ON_ONE    = 5'h04;
	localparam logic [4:0] ADDR_ON_TWO    = 5'h05;
	localparam logic [4:0] ADDR_OFF_ONE   = 5'h06;
	localparam logic [4:0] ADDR_OFF_TWO   = 5'h07;
	localparam logic [4:0] ADDR_INT_EN    = 5'h08;
	localparam logic [4:0] ADDR_FIFO_CTL  = 5'h09;
	localparam logic [4:0] ADDR_INT_STAT  = 5'h0A;
	localparam logic [4:0] ADDR_LINE_CTL  = 5'h0B;
	localparam logic [4:0] ADDR_MODEM_CTL = 5'h0C;
	localparam logic [4:0] ADDR_LINE_STAT = 5'h0D;
	localparam logic [4:0] ADDR_MODEM_ST  = 5'h0E;
	localparam logic [4:0] ADDR_THRESH    = 5'h0F;
	localparam logic [4:0] ADDR_TRIGGER   = 5'h10;
	localparam logic [4:0] ADDR_TX_SPACE  = 5'h11;
	localparam logic [4:0] ADDR_RX_FILL   = 5'h12;
	localparam logic [4:0] ADDR_SCRATCH   = 5'h13;
	localparam logic [4:0] ADDR_GPIO_CTL  = 5'h14;
	localparam logic [4:0] ADDR_EXTRA     = 5'h15;

	// ----------------------------------------------------------------
	// values after reset, plus the flow interrupt status code
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_DIV_LOW   = 8'h01;
	localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
	localparam logic [7:0] RST_SCRATCH   = 8'hFF;
	localparam logic [7:0] RST_FLOW_CHAR = 8'h00;
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_INT_STAT  = 8'h01;
	localparam logic [7:0] RST_LINE_CTL  = 8'h1D;
	localparam logic [7:0] RST_LINE_STAT = 8'h60;
	localparam logic [7:0] RST_THRESH    = 8'h0F;
	localparam logic [7:0] RST_TX_SPACE  = 8'h40;
	localparam logic [7:0] INT_STAT_FLOW = 8'h10;
	localparam logic [3:0] RST_MODEM_IN  = 4'hF;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int EN_BIT       = 4;
	localparam int SPECIAL_BIT  = 5;
	localparam int AUTO_RTS_BIT = 6;
	localparam int AUTO_CTS_BIT = 7;
	localparam int IE_FLOW_BIT  = 5;
	localparam int SOFT_RST_BIT = 3;
	localparam int TX_DIS_BIT   = 2;
	localparam int MC_RTS_BIT   = 1;
	localparam int MC_DTR_BIT   = 0;

	// ----------------------------------------------------------------
	// counts
	// ----------------------------------------------------------------
	localparam logic [6:0]  FIFO_DEPTH_COUNT = 7'd64;
	localparam logic [20:0] PHASE_STEP       = 21'd16;
	localparam logic [3:0]  LAST_SAMPLE_16X  = 4'd15;
	localparam logic [3:0]  LAST_SAMPLE_8X   = 4'd7;
	localparam logic [3:0]  LAST_SAMPLE_4X   = 4'd3;

	typedef enum logic [1:0] {
		FLOW_NONE,
		FLOW_SECOND,
		FLOW_FIRST,
		FLOW_BOTH
	} flow_sel_t;

	typedef enum {
		TX_FLOW_RUNNING,
		TX_FLOW_HALTED
	} tx_flow_state_t;

endpackage

/* File: hdl/char_buffer.sv */
// small shifting buffer in the received-character path
// assumes push and pop from logic on the same clock
`timescale 1ns/1ns
module char_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [CW-1:0]    count;
	logic             push;
	logic             pop;
	logic [CW-1:0]    next_count;

	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;
	assign out_data = mem[0];

	always_comb begin
		next_count = count;
		if (push && !pop)
			next_count = count + CW'(1);
		else if (pop && !push)
			next_count = count - CW'(1);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else if (ce) begin
			count     <= next_count;
			in_ready  <= next_count < CW'(DEPTH);
			out_valid <= next_count != '0;
		end
	end

	// entries slide toward the head so the head is always a plain flop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
		end else if (ce) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (pop && i < DEPTH - 1 && CW'(i + 1) < count)
					mem[i] <= mem[i + 1];
				if (push && CW'(i) == (pop ? count - CW'(1) : count))
					mem[i] <= in_data;
			end
		end
	end

endmodule // char_buffer

/* File: hdl/uart_flow_ctrl.sv */
// baud generator, enhanced-feature registers and flow control of a uart
// assumes receiver, transmitter and fifos outside, on the same clock
//
// Function
// - divisor is high:low bytes plus fraction nibble over sixteen
// - fraction register reachable only while enhanced enable is set
// - fraction bits 5:4 pick 16x, 8x or 4x sampling; 16x default
// - transmit flow bits pick first pair, second pair, both, or none
// - receive flow bits compare first pair, second pair, both, or nothing
// - receive 11 with transmit 10/01 accepts either single character
// - receive 11 with transmit 11/00 needs the sequential two-char pair
// - enhanced bits writable only while enhanced enable is one
// - reset clears upper enhanced bits and fraction register
// - special detect compares each character with second off char
// - special detect with first-pair receive: both work normally
// - second-pair receive: second off char dropped, raises interrupt
// - auto request-to-send high at halt level, low below resume
// - auto clear-to-send stops transmit while remote holds it high
// - modem status change bits clear; upper bits show inverted inputs
// - divisor, scratch and flow characters reset only at power-up
// - halt and resume levels are threshold nibbles times four
`timescale 1ns/1ns
module uart_flow_ctrl
	import uart_flow_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       por_n,
	input  wire logic       ce,
	input  wire logic [4:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	input  wire logic       rx_char_valid,
	input  wire logic [7:0] rx_char,
	output logic            rx_char_ready,
	output logic            store_valid,
	output logic [7:0]      store_data,
	input  wire logic       store_ready,
	input  wire logic [6:0] rx_fill_count,
	input  wire logic [6:0] tx_space_count,
	input  wire logic [3:0] modem_in_n,
	input  wire logic       tx_serial,
	output logic            tx_out,
	output logic            rts_n,
	output logic            dtr_n,
	output logic            irq_n,
	output logic            tx_allowed,
	output logic            flow_send_valid,
	output logic [15:0]     flow_send_chars,
	output logic            flow_send_two,
	output logic            sample_tick,
	output logic            bit_tick
);
	import uart_flow_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] level4(input logic [3:0] nib);
		return {1'b0, nib, 2'b00};
	endfunction

	function automatic logic hit(input logic [4:0] a);
		return reg_addr == a;
	endfunction

	logic [7:0] div_low, div_high, fraction, enhanced;
	logic [7:0] on_one, on_two, off_one, off_two, scratch;
	logic [7:0] int_en, fifo_ctl, line_ctl, modem_ctl, thresh, trigger;
	logic [7:0] gpio_ctl, extra, line_stat, tx_space, rx_fill;
	logic [3:0] modem_delta;
	logic       soft_rst, flow_flag, remote_halted, rts_hold;
	logic       pend_off, pend_on;
	logic       en;
	logic [3:0] modem_s1;
	logic [3:0] modem_s2, modem_s3, modem_filt;

	assign en = enhanced[EN_BIT];

	// ----------------------------------------------------------------
	// power-up-only registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			div_low  <= RST_DIV_LOW;
			div_high <= RST_DIV_HIGH;
			scratch  <= RST_SCRATCH;
			on_one   <= RST_FLOW_CHAR;
			on_two   <= RST_FLOW_CHAR;
			off_one  <= RST_FLOW_CHAR;
			off_two  <= RST_FLOW_CHAR;
		end else if (ce && reg_wr) begin
			if (hit(ADDR_DIV_LOW))  div_low  <= reg_wdata;
			if (hit(ADDR_DIV_HIGH)) div_high <= reg_wdata;
			if (hit(ADDR_SCRATCH))  scratch  <= reg_wdata;
			if (hit(ADDR_ON_ONE))   on_one   <= reg_wdata;
			if (hit(ADDR_ON_TWO))   on_two   <= reg_wdata;
			if (hit(ADDR_OFF_ONE))  off_one  <= reg_wdata;
			if (hit(ADDR_OFF_TWO))  off_two  <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// software reset pulse
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			soft_rst <= 1'b0;
		else if (ce)
			soft_rst <= reg_wr && hit(ADDR_GPIO_CTL) && reg_wdata[SOFT_RST_BIT];
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{fraction, enhanced, int_en, fifo_ctl} <= {4{RST_ZERO}};
			{modem_ctl, trigger, gpio_ctl, extra} <= {4{RST_ZERO}};
			line_ctl <= RST_LINE_CTL;
			thresh   <= RST_THRESH;
		end else if (ce) begin
			if (soft_rst) begin
				{fraction, enhanced, int_en, fifo_ctl} <= {4{RST_ZERO}};
				{modem_ctl, trigger, gpio_ctl, extra} <= {4{RST_ZERO}};
				line_ctl <= RST_LINE_CTL;
				thresh   <= RST_THRESH;
			end else if (reg_wr) begin
				if (hit(ADDR_ENHANCED)) enhanced <= reg_wdata;
				if (hit(ADDR_FRACTION) && en) fraction <= reg_wdata;
				if (hit(ADDR_THRESH) && en)   thresh   <= reg_wdata;
				if (hit(ADDR_TRIGGER) && en)  trigger  <= reg_wdata;
				if (hit(ADDR_INT_EN)) begin
					int_en[3:0] <= reg_wdata[3:0];
					if (en) int_en[7:4] <= reg_wdata[7:4];
				end
				if (hit(ADDR_FIFO_CTL)) begin
					fifo_ctl[7:6] <= reg_wdata[7:6];
					fifo_ctl[3:0] <= reg_wdata[3:0];
					if (en) fifo_ctl[5:4] <= reg_wdata[5:4];
				end
				if (hit(ADDR_MODEM_CTL)) begin
					{modem_ctl[4:3], modem_ctl[1:0]} <= {reg_wdata[4:3], reg_wdata[1:0]};
					if (en) begin
						modem_ctl[7:5] <= reg_wdata[7:5];
						modem_ctl[2]   <= reg_wdata[2];
					end
				end
				if (hit(ADDR_LINE_CTL)) line_ctl <= reg_wdata;
				// reset bit is self-clearing, so it is never stored
				if (hit(ADDR_GPIO_CTL)) gpio_ctl <= reg_wdata & 8'hF7;
				if (hit(ADDR_EXTRA))    extra    <= reg_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// modem inputs: three flops, change taken when stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modem_s1   <= RST_MODEM_IN;
			modem_s2   <= RST_MODEM_IN;
			modem_s3   <= RST_MODEM_IN;
			modem_filt <= RST_MODEM_IN;
		end else if (ce) begin
			modem_s1 <= modem_in_n;
			modem_s2 <= modem_s1;
			modem_s3 <= modem_s2;
			for (int i = 0; i < 4; i++)
				if (modem_s2[i] == modem_s3[i])
					modem_filt[i] <= modem_s3[i];
		end
	end

	// ----------------------------------------------------------------
	// receive character checks
	// ----------------------------------------------------------------
	flow_sel_t  rx_sel, tx_sel;
	logic       accept, pair_mode, either_mode;
	logic       is_on1, is_on2, is_off1, is_off2;
	logic       on_hit, off_hit, single_hit, special_hit, drop;

	assign rx_sel      = flow_sel_t'(enhanced[1:0]);
	assign tx_sel      = flow_sel_t'(enhanced[3:2]);
	assign is_on1      = rx_char == on_one;
	assign is_on2      = rx_char == on_two;
	assign is_off1     = rx_char == off_one;
	assign is_off2     = rx_char == off_two;
	assign either_mode = rx_sel == FLOW_BOTH && (tx_sel == FLOW_FIRST || tx_sel == FLOW_SECOND);
	assign pair_mode   = rx_sel == FLOW_BOTH && (tx_sel == FLOW_BOTH || tx_sel == FLOW_NONE);
	assign accept      = rx_char_valid && rx_char_ready;

	always_comb begin
		on_hit  = 1'b0;
		off_hit = 1'b0;
		unique case (rx_sel)
			FLOW_NONE: begin
			end
			FLOW_FIRST: begin
				on_hit  = is_on1;
				off_hit = is_off1;
			end
			FLOW_SECOND: begin
				on_hit  = is_on2;
				off_hit = is_off2;
			end
			FLOW_BOTH: begin
				if (either_mode) begin
					on_hit  = is_on1 || is_on2;
					off_hit = is_off1 || is_off2;
				end else begin
					on_hit  = pend_on && is_on2;
					off_hit = pend_off && is_off2;
				end
			end
		endcase
	end

	// single flow characters are consumed; pair characters pass through
	assign single_hit  = (on_hit || off_hit) && !pair_mode;
	assign special_hit = enhanced[SPECIAL_BIT] && is_off2;
	// first-pair mode: second off char is not a flow char, so it is stored
	assign drop        = single_hit;

	char_buffer #(
		.WIDTH (8),
		.DEPTH (BUF_DEPTH)
	) u_buffer (
		.clk       (clk),
		.rstn      (rstn),
		.ce        (ce),
		.in_valid  (rx_char_valid && !drop),
		.in_ready  (rx_char_ready),
		.in_data   (rx_char),
		.out_valid (store_valid),
		.out_ready (store_ready),
		.out_data  (store_data)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend_off      <= 1'b0;
			pend_on       <= 1'b0;
			remote_halted <= 1'b0;
		end else if (ce) begin
			if (soft_rst || rx_sel == FLOW_NONE) begin
				pend_off      <= 1'b0;
				pend_on       <= 1'b0;
				remote_halted <= 1'b0;
			end else if (accept) begin
				pend_off <= pair_mode && is_off1;
				pend_on  <= pair_mode && is_on1;
				if (off_hit)
					remote_halted <= 1'b1;
				else if (on_hit)
					remote_halted <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// status registers
	// ----------------------------------------------------------------
	logic rd_stat, rd_modem;
	assign rd_stat  = reg_rd && hit(ADDR_INT_STAT);
	assign rd_modem = reg_rd && hit(ADDR_MODEM_ST);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flow_flag   <= 1'b0;
			modem_delta <= 4'h0;
			line_stat   <= RST_LINE_STAT;
			tx_space    <= RST_TX_SPACE;
			rx_fill     <= RST_ZERO;
		end else if (ce) begin
			line_stat <= (tx_space_count == FIFO_DEPTH_COUNT) ? RST_LINE_STAT : RST_ZERO;
			tx_space  <= {1'b0, tx_space_count};
			rx_fill   <= {1'b0, rx_fill_count};
			if (soft_rst) begin
				flow_flag   <= 1'b0;
				modem_delta <= 4'h0;
			end else begin
				// an event in the clearing cycle is kept
				if (accept && (off_hit || special_hit))
					flow_flag <= 1'b1;
				else if (rd_stat)
					flow_flag <= 1'b0;
				modem_delta <= (rd_modem ? 4'h0 : modem_delta) | ((modem_filt ^ modem_s3) &
					~(modem_s2 ^ modem_s3));
			end
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			reg_rdata <= RST_ZERO;
		else if (ce && reg_rd) begin
			unique case (reg_addr)
				ADDR_DIV_LOW:   reg_rdata <= div_low;
				ADDR_DIV_HIGH:  reg_rdata <= div_high;
				ADDR_FRACTION:  reg_rdata <= en ? fraction : RST_ZERO;
				ADDR_ENHANCED:  reg_rdata <= enhanced;
				ADDR_ON_ONE:    reg_rdata <= on_one;
				ADDR_ON_TWO:    reg_rdata <= on_two;
				ADDR_OFF_ONE:   reg_rdata <= off_one;
				ADDR_OFF_TWO:   reg_rdata <= off_two;
				ADDR_INT_EN:    reg_rdata <= int_en;
				ADDR_FIFO_CTL:  reg_rdata <= fifo_ctl;
				ADDR_INT_STAT:  reg_rdata <= (flow_flag && int_en[IE_FLOW_BIT]) ?
					INT_STAT_FLOW : RST_INT_STAT;
				ADDR_LINE_CTL:  reg_rdata <= line_ctl;
				ADDR_MODEM_CTL: reg_rdata <= modem_ctl;
				ADDR_LINE_STAT: reg_rdata <= line_stat;
				ADDR_MODEM_ST:  reg_rdata <= {~modem_filt, modem_delta};
				ADDR_THRESH:    reg_rdata <= thresh;
				ADDR_TRIGGER:   reg_rdata <= trigger;
				ADDR_TX_SPACE:  reg_rdata <= tx_space;
				ADDR_RX_FILL:   reg_rdata <= rx_fill;
				ADDR_SCRATCH:   reg_rdata <= scratch;
				ADDR_GPIO_CTL:  reg_rdata <= gpio_ctl;
				ADDR_EXTRA:     reg_rdata <= extra;
				default:        reg_rdata <= RST_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// hardware and transmit flow control
	// ----------------------------------------------------------------
	logic [6:0]     halt_level, resume_level;
	tx_flow_state_t tx_state;

	assign halt_level   = level4(thresh[3:0]);
	assign resume_level = level4(thresh[7:4]);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rts_hold   <= 1'b0;
			rts_n      <= 1'b1;
			dtr_n      <= 1'b1;
			irq_n      <= 1'b1;
			tx_out     <= 1'b1;
			tx_allowed <= 1'b0;
		end else if (ce) begin
			if (rx_fill_count >= halt_level)
				rts_hold <= 1'b1;
			else if (rx_fill_count < resume_level)
				rts_hold <= 1'b0;
			// auto mode only raises a pin that software has driven low
			rts_n  <= !modem_ctl[MC_RTS_BIT] ||
				(enhanced[AUTO_RTS_BIT] && rts_hold);
			dtr_n  <= !modem_ctl[MC_DTR_BIT];
			irq_n  <= !(flow_flag && int_en[IE_FLOW_BIT]);
			tx_out <= extra[TX_DIS_BIT] || tx_serial;
			tx_allowed <= !(enhanced[AUTO_CTS_BIT] && modem_filt[0]) && !remote_halted;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_state        <= TX_FLOW_RUNNING;
			flow_send_valid <= 1'b0;
			flow_send_chars <= 16'h0000;
			flow_send_two   <= 1'b0;
		end else if (ce) begin
			flow_send_valid <= 1'b0;
			if (soft_rst || tx_sel == FLOW_NONE) begin
				tx_state <= TX_FLOW_RUNNING;
			end else begin
				unique case (tx_state)
					TX_FLOW_RUNNING: if (rx_fill_count >= halt_level) begin
						tx_state        <= TX_FLOW_HALTED;
						flow_send_valid <= 1'b1;
						flow_send_two   <= tx_sel == FLOW_BOTH;
						flow_send_chars <= (tx_sel == FLOW_SECOND) ? {8'h00, off_two} :
							(tx_sel == FLOW_BOTH) ? {off_two, off_one} : {8'h00, off_one};
					end
					TX_FLOW_HALTED: if (rx_fill_count <= resume_level) begin
						tx_state        <= TX_FLOW_RUNNING;
						flow_send_valid <= 1'b1;
						flow_send_two   <= tx_sel == FLOW_BOTH;
						flow_send_chars <= (tx_sel == FLOW_SECOND) ? {8'h00, on_two} :
							(tx_sel == FLOW_BOTH) ? {on_two, on_one} : {8'h00, on_one};
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// fractional baud generator
	// ----------------------------------------------------------------
	logic [20:0] divisor16, phase, phase_sum;
	logic [3:0]  sample_cnt, last_sample;

	assign divisor16 = {1'b0, div_high, div_low, fraction[3:0]};
	assign phase_sum = phase + PHASE_STEP;
	assign last_sample = fraction[5] ? LAST_SAMPLE_4X :
		fraction[4] ? LAST_SAMPLE_8X : LAST_SAMPLE_16X;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase       <= '0;
			sample_cnt  <= '0;
			sample_tick <= 1'b0;
			bit_tick    <= 1'b0;
		end else if (ce) begin
			sample_tick <= 1'b0;
			bit_tick    <= 1'b0;
			// nonzero divisors of one or less saturate at one tick a cycle; zero stops the ticks
			if (divisor16 == '0 || soft_rst) begin
				phase      <= '0;
				sample_cnt <= '0;
			end else if (phase_sum >= divisor16) begin
				phase       <= (phase_sum - divisor16 >= divisor16) ? '0 : phase_sum - divisor16;
				sample_tick <= 1'b1;
				sample_cnt  <= (sample_cnt >= last_sample) ? 4'd0 : sample_cnt + 4'd1;
				bit_tick    <= sample_cnt >= last_sample;
			end else begin
				phase <= phase_sum;
			end
		end
	end

endmodule // uart_flow_ctrl

/* File: tb/uart_flow_chk.sv */
// assertions on the top ports of uart_flow_ctrl
// bound from the bench top; one clock, rstn async low
`timescale 1ns/1ns
module uart_flow_chk
	import uart_flow_pkg::*;
#(parameter int BUF_DEPTH = 2) (
	input wire logic       clk, rstn, ce, reg_rd, tx_serial, tx_out, rts_n, dtr_n,
	input wire logic       irq_n, rx_char_valid, rx_char_ready, store_valid,
	input wire logic       store_ready, flow_send_valid,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_rdata, store_data,
	input wire logic [6:0] tx_space_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_idle; $rose(rstn) |-> rts_n && dtr_n && irq_n && tx_out; endproperty
	a_idle: assert property (p_idle) else $error("pins not idle");
	property p_tx; !tx_out |-> !$past(tx_serial); endproperty
	a_tx: assert property (p_tx) else $error("tx low");
	property p_keep; store_valid && !store_ready |=> store_valid && $stable(store_data);
	endproperty
	a_keep: assert property (p_keep) else $error("char lost");
	property p_full; !rx_char_ready |-> store_valid; endproperty
	a_full: assert property (p_full) else $error("refused");
	property p_new; $rose(store_valid) |-> $past(rx_char_valid && rx_char_ready); endproperty
	a_new: assert property (p_new) else $error("stray char");
	property p_pulse; flow_send_valid |=> !flow_send_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
	property p_lsr; reg_rd && ce && reg_addr == ADDR_LINE_STAT && tx_space_count == 7'd64
		|=> reg_rdata == RST_LINE_STAT; endproperty
	a_lsr: assert property (p_lsr) else $error("bad status");
	c_flow: cover property (flow_send_valid);
	c_stall: cover property (store_valid && !store_ready);
	c_halt: cover property ($rose(rts_n));
endmodule // uart_flow_chk

/* File: tb/remote_dev.sv */
// far side: takes chars, drives clear-to-send
// same clock as the bench; stall stops it taking chars
`timescale 1ns/1ns
module remote_dev (
	input  wire logic  clk,
	input  wire logic  stall,
	input  wire logic  cts_high,
	output logic       store_ready,
	output logic [3:0] modem_in_n
);
	initial store_ready = 1'b1;
	always @(posedge clk) store_ready <= !stall;
	// other modem pins idle high
	assign modem_in_n = {3'b111, cts_high};
endmodule // remote_dev

/* File: tb/uart_flow_ctrl_tb.sv */
// bench for uart_flow_ctrl via its register port and char path
// remote_dev is the far side; ce held on
`timescale 1ns/1ns
module uart_flow_ctrl_tb;
	import uart_flow_pkg::*;
	logic        clk, rstn, por_n, reg_wr, reg_rd, rx_char_valid, tx_serial, stall;
	logic        cts_high, rx_char_ready, store_valid, store_ready, tx_out, rts_n;
	logic        dtr_n, irq_n, tx_allowed, flow_send_valid, flow_send_two, sample_tick, bit_tick;
	logic [4:0]  reg_addr;
	logic [7:0]  reg_wdata, rx_char, reg_rdata, store_data, q[$];
	logic [6:0]  fill;
	logic [3:0]  modem_in_n;
	logic [15:0] flow_send_chars;
	int          fails, cmp_count, cyc, nt, nb;
	logic [4:0]  ra [9] = '{ADDR_LINE_CTL, ADDR_INT_STAT, ADDR_LINE_STAT, ADDR_THRESH,
		ADDR_TX_SPACE, ADDR_DIV_LOW, ADDR_SCRATCH, ADDR_ENHANCED, ADDR_MODEM_ST};
	logic [7:0]  rv [9] = '{8'h1D, 8'h01, 8'h60, 8'h0F, 8'h40, 8'h01, 8'hFF, 8'h00, 8'h00};
	logic [7:0]  qe [8] = '{8'h41, 8'h42, 8'h13, 8'h5A, 8'h11, 8'h12, 8'h61, 8'h62};
	uart_flow_ctrl dut (.clk, .rstn, .por_n, .ce(1'b1), .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .rx_char_valid, .rx_char, .rx_char_ready, .store_valid,
		.store_data, .store_ready, .rx_fill_count(fill), .tx_space_count(7'd64),
		.modem_in_n, .tx_serial, .tx_out, .rts_n, .dtr_n, .irq_n, .tx_allowed,
		.flow_send_valid, .flow_send_chars, .flow_send_two, .sample_tick, .bit_tick);
	remote_dev peer (.clk, .stall, .cts_high, .store_ready, .modem_in_n);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		tx_serial <= ~tx_serial;
		if (store_valid && store_ready) q.push_back(store_data);
		if (++cyc == 9000) begin
			fails++;
			complete_run();
		end
	end
	task complete_run();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] g, e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge clk);
		#1 reg_wr = 0;
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 {reg_addr, reg_rd} = {a, 1'b1};
		@(posedge clk);
		#1 reg_rd = 0;
		chk("rdata", reg_rdata, e);
	endtask
	task snd(input logic [7:0] c);
		@(posedge clk);
		#1 {rx_char_valid, rx_char} = {1'b1, c};
		@(posedge clk);
		while (rx_char_ready !== 1) @(posedge clk);
		#1 rx_char_valid = 0;
	endtask
	task wp(input logic [15:0] e);
		for (int i = 0; i < 30 && flow_send_valid !== 1; i++) wt(1);
		chk("flow", flow_send_two ? flow_send_chars : {8'h00, flow_send_chars[7:0]}, e);
		wt(1);
	endtask
	initial begin
		{rstn, por_n, reg_wr, reg_rd, rx_char_valid, stall, reg_addr, fill} = 0;
		{cts_high, tx_serial, reg_wdata, rx_char} = 18'h3_0000;
		wt(5);
		#1 {rstn, por_n} = 2'b11;
		foreach (ra[k]) rd(ra[k], rv[k]);
		wr(ADDR_FRACTION, 8'h35);
		rd(ADDR_FRACTION, 8'h00);
		wr(ADDR_ENHANCED, 8'h10);
		wr(ADDR_DIV_LOW, 8'h02);
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_FRACTION, 8'(8'h08 | (k << 4)));
			nt = 0;
			nb = 0;
			repeat (400) @(posedge clk) begin
				nt += sample_tick;
				nb += bit_tick;
			end
			chk("sample", nt inside {[158:162]}, 1);
			chk("bit", nb inside {[(10 << k) - 1:(10 << k) + 1]}, 1);
		end
		wr(ADDR_ENHANCED, 8'h00);
		wr(ADDR_FRACTION, 8'h35);
		wr(ADDR_ENHANCED, 8'h10);
		rd(ADDR_FRACTION, 8'h28);
		rstn = 0;
		wt(1);
		#1 rstn = 1;
		rd(ADDR_DIV_LOW, 8'h02);
		wr(ADDR_ENHANCED, 8'h10);
		rd(ADDR_FRACTION, 8'h00);
		wr(ADDR_OFF_ONE, 8'h13);
		wr(ADDR_ON_ONE, 8'h11);
		wr(ADDR_OFF_TWO, 8'h5A);
		wr(ADDR_ON_TWO, 8'h12);
		wr(ADDR_INT_EN, 8'h20);
		wr(ADDR_ENHANCED, 8'h12);
		snd(8'h13);
		snd(8'h41);
		wt(3);
		chk("halt", tx_allowed, 0);
		snd(8'h11);
		wt(3);
		chk("go", tx_allowed, 1);
		rd(ADDR_INT_STAT, INT_STAT_FLOW);
		wr(ADDR_ENHANCED, 8'h10);
		wr(ADDR_ENHANCED, 8'h31);
		snd(8'h5A);
		snd(8'h42);
		chk("irq", irq_n, 0);
		rd(ADDR_INT_STAT, INT_STAT_FLOW);
		wr(ADDR_ENHANCED, 8'h10);
		wr(ADDR_ENHANCED, 8'h13);
		snd(8'h13);
		snd(8'h5A);
		wt(3);
		chk("pair", tx_allowed, 0);
		snd(8'h11);
		snd(8'h12);
		wt(3);
		chk("pair", tx_allowed, 1);
		wr(ADDR_ENHANCED, 8'h10);
		stall = 1;
		snd(8'h61);
		snd(8'h62);
		wt(2);
		chk("full", rx_char_ready, 0);
		stall = 0;
		wt(6);
		chk("count", 16'(q.size()), 8);
		foreach (qe[k]) chk("store", q[k], qe[k]);
		wr(ADDR_THRESH, 8'h12);
		wr(ADDR_MODEM_CTL, 8'h03);
		wr(ADDR_ENHANCED, 8'h50);
		chk("dtr", dtr_n, 0);
		fill = 7'd8;
		wt(4);
		chk("rts", rts_n, 1);
		fill = 7'd3;
		wt(4);
		chk("rts", rts_n, 0);
		for (int k = 1; k < 4; k++) begin
			wr(ADDR_ENHANCED, 8'h10);
			wr(ADDR_ENHANCED, 8'(8'h10 | (k << 2)));
			fill = 7'd8;
			wp(k == 3 ? 16'h5A13 : (k == 1 ? 16'h005A : 16'h0013));
			fill = 7'd0;
			wp(k == 3 ? 16'h1211 : (k == 1 ? 16'h0012 : 16'h0011));
		end
		wr(ADDR_ENHANCED, 8'h10);
		wr(ADDR_ENHANCED, 8'h90);
		cts_high = 0;
		wt(8);
		chk("cts", tx_allowed, 1);
		rd(ADDR_MODEM_ST, 8'h11);
		cts_high = 1;
		wt(8);
		chk("cts", tx_allowed, 0);
		complete_run();
	end
endmodule // uart_flow_ctrl_tb
bind uart_flow_ctrl uart_flow_chk #(.BUF_DEPTH(BUF_DEPTH)) chk (.clk, .rstn, .ce, .reg_rd,
	.tx_serial, .tx_out, .rts_n, .dtr_n, .irq_n, .rx_char_valid, .rx_char_ready,
	.store_valid, .store_ready, .flow_send_valid, .reg_addr, .reg_rdata, .store_data,
	.tx_space_count);
